// File: pkg/ibs_pkg.sv
package ibs_pkg;
   localparam int DATA_W          = 8;
   localparam int ADDR_W          = 12;
   localparam int INSN_W          = 16;
   // opcode layouts
   localparam logic [3:0] OP_BITSET_HI   = 4'h8;  // 1000 bbb a kkkkkkkk
   localparam logic [7:0] OP_FILL_HI     = 8'h68; // 0110 1000 kkkkkkkk
   localparam int          BIT_LSB        = 9;
   localparam int          ACC_BIT        = 8;
   localparam logic [7:0] OFFSET_MAX     = 8'h5F;
   localparam logic [7:0] FILL_VALUE     = 8'hFF;
   localparam logic [ADDR_W-1:0] PTR_RESET = 12'h000;

   typedef enum logic [3:0] {
      ST_DECODE  = 4'h1,
      ST_READ    = 4'h2,
      ST_PROCESS = 4'h4,
      ST_WRITE   = 4'h8
   } ibs_phase_e;

   typedef struct packed {
      logic              valid;
      logic [INSN_W-1:0] word;
   } ibs_insn_s;

   typedef struct packed {
      logic              rd;
      logic              wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } ibs_mem_s;
endpackage : ibs_pkg

// File: verilog/ibs_decode.sv
`timescale 1ns/1ps
module ibs_decode
   import ibs_pkg::*;
(
   input  wire logic [INSN_W-1:0] word,
   input  wire logic              ext_en,
   output logic                   is_bitset,
   output logic                   is_fill,
   output logic [2:0]             bit_sel,
   output logic [7:0]             offset
);
   logic indexed;

   always_comb
   begin
      offset  = word[7:0];
      bit_sel = word[BIT_LSB+2:BIT_LSB];
      // access-bank form with low operand is an offset only when extended
      indexed   = ext_en && (word[ACC_BIT] == 1'b0) && (word[7:0] <= OFFSET_MAX);
      is_bitset = indexed && (word[15:12] == OP_BITSET_HI);
      is_fill   = indexed && (word[15:8] == OP_FILL_HI);
   end
endmodule : ibs_decode

// File: verilog/ibs_exec.sv
`timescale 1ns/1ps
module ibs_exec
   import ibs_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              nrst,
   input  wire ibs_insn_s         insn,
   input  wire logic              extended_set_enable,
   input  wire logic [ADDR_W-1:0] stack_frame_pointer,
   input  wire logic [DATA_W-1:0] mem_rdata,
   output ibs_mem_s               mem,
   output logic                   insn_accept,
   output logic                   insn_done,
   output logic                   insn_unclaimed
);
   logic                    is_bitset;
   logic                    is_fill;
   logic [2:0]              bit_sel;
   logic [7:0]              offset;
   ibs_phase_e              phase_q, phase_d;
   logic                    kind_bitset_q, kind_bitset_d;
   logic [2:0]              bit_q, bit_d;
   logic [ADDR_W-1:0]       addr_q, addr_d;
   logic [DATA_W-1:0]       data_q, data_d;
   ibs_mem_s                mem_q, mem_d;
   logic                    accept_q, accept_d;
   logic                    done_q, done_d;
   logic                    uncl_q, uncl_d;
   logic                    ext_meta_q, ext_q;

   // the enable is a configuration level from outside this domain
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ext_meta_q <= 1'b0;
         ext_q      <= 1'b0;
      end
      else
      begin
         ext_meta_q <= extended_set_enable;
         ext_q      <= ext_meta_q;
      end
   end

   ibs_decode u_dec (
      .word      (insn.word),
      .ext_en    (ext_q),
      .is_bitset (is_bitset),
      .is_fill   (is_fill),
      .bit_sel   (bit_sel),
      .offset    (offset)
   );

   always_comb
   begin
      phase_d       = phase_q;
      kind_bitset_d = kind_bitset_q;
      bit_d         = bit_q;
      addr_d        = addr_q;
      data_d        = data_q;
      mem_d         = '0;
      accept_d      = 1'b0;
      done_d        = 1'b0;
      uncl_d        = 1'b0;
      case (phase_q)
         ST_DECODE:
         begin
            if (insn.valid)
            begin
               if (is_bitset || is_fill)
               begin
                  accept_d      = 1'b1;
                  kind_bitset_d = is_bitset;
                  bit_d         = bit_sel;
                  // zero-extended offset on the pointer; wraps in the data space
                  addr_d        = stack_frame_pointer + {{(ADDR_W-8){1'b0}}, offset};
                  phase_d       = ST_READ;
               end
               else
               begin
                  // legacy or other forms belong to the rest of the core
                  uncl_d = 1'b1;
               end
            end
         end
         ST_READ:
         begin
            mem_d.rd   = kind_bitset_q;
            mem_d.addr = addr_q;
            phase_d    = ST_PROCESS;
         end
         ST_PROCESS:
         begin
            // read byte is not back yet; only the operand is formed here
            if (kind_bitset_q)
               data_d = 8'h01 << bit_q;
            else
               data_d = FILL_VALUE;
            phase_d = ST_WRITE;
         end
         ST_WRITE:
         begin
            // no status flag port exists: flags are untouched
            mem_d.wr    = 1'b1;
            mem_d.addr  = addr_q;
            // registered memory answers one cycle after rd, i.e. in this cycle
            mem_d.wdata = kind_bitset_q ? (mem_rdata | data_q) : data_q;
            done_d      = 1'b1;
            phase_d     = ST_DECODE;
         end
         default:
            phase_d = ST_DECODE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         phase_q       <= ST_DECODE;
         kind_bitset_q <= 1'b0;
         bit_q         <= 3'h0;
         addr_q        <= PTR_RESET;
         data_q        <= 8'h00;
         mem_q         <= '0;
         accept_q      <= 1'b0;
         done_q        <= 1'b0;
         uncl_q        <= 1'b0;
      end
      else
      begin
         phase_q       <= phase_d;
         kind_bitset_q <= kind_bitset_d;
         bit_q         <= bit_d;
         addr_q        <= addr_d;
         data_q        <= data_d;
         mem_q         <= mem_d;
         accept_q      <= accept_d;
         done_q        <= done_d;
         uncl_q        <= uncl_d;
      end
   end

   assign mem            = mem_q;
   assign insn_accept    = accept_q;
   assign insn_done      = done_q;
   assign insn_unclaimed = uncl_q;

   // assertions
   logic [ADDR_W-1:0] exp_addr_q;
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         exp_addr_q <= 12'h000;
      else if (insn.valid && phase_q == ST_DECODE)
         exp_addr_q <= stack_frame_pointer + {4'h0, insn.word[7:0]};
   end

   sequence s_claim;
      insn.valid && phase_q == ST_DECODE && (is_bitset || is_fill);
   endsequence

   sequence s_write;
      (mem.wr && insn_done) ##1 (!mem.wr && !insn_done);
   endsequence

   addr_sum_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_claim |=> ##3 (mem.addr == exp_addr_q))
      else $error("write address is not pointer plus offset");

   bit_only_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (phase_q == ST_WRITE && kind_bitset_q) |=>
         (mem.wr && ((mem.wdata ^ $past(mem_rdata)) == ((8'h01 << $past(bit_q)) & ~$past(mem_rdata)))))
      else $error("bit set touched other bits");

   fill_ones_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (insn.valid && phase_q == ST_DECODE && is_fill) |-> ##4 (mem.wr && mem.wdata == 8'hFF))
      else $error("fill did not write all ones");

   fill_addr_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (insn.valid && phase_q == ST_DECODE && is_fill) |-> ##4 (mem.addr == exp_addr_q))
      else $error("fill address wrong");

   low_operand_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (insn.valid && phase_q == ST_DECODE && ext_q && !insn.word[ACC_BIT]
       && insn.word[7:0] <= 8'h5F && insn.word[15:8] == 8'h68) |=> accept_q)
      else $error("low access operand not taken as offset");

   high_operand_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (insn.valid && phase_q == ST_DECODE && insn.word[7:0] > 8'h5F) |=> !accept_q)
      else $error("high operand taken as offset");

   ext_off_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (!ext_q && phase_q == ST_DECODE) |=> !accept_q)
      else $error("extended form accepted while disabled");

   one_cycle_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_claim |=> accept_q ##3 s_write)
      else $error("instruction did not finish in four phases");
endmodule : ibs_exec

// File: testbench/ibs_mem_model.sv
`timescale 1ns/1ps
module ibs_mem_model
   import ibs_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire ibs_mem_s          mem,
   output logic [DATA_W-1:0]      mem_rdata
);
   logic [DATA_W-1:0] m [0:(1<<ADDR_W)-1];
   initial mem_rdata = 8'h00;
   // read data lives one cycle; then flipped so a stale byte never passes
   always @(posedge ref_clk)
   begin
      if (mem.wr)
         m[mem.addr] <= mem.wdata;
      mem_rdata <= mem.rd ? m[mem.addr] : ~mem_rdata;
   end
endmodule : ibs_mem_model

// File: testbench/indexed_bit_set_fill_exec_tb_top.sv
`timescale 1ns/1ps
module indexed_bit_set_fill_exec_tb_top
   import ibs_pkg::*;
;
   logic              ref_clk = 1'b0;
   logic              nrst    = 1'b0;
   ibs_insn_s         insn    = '0;
   logic              ext     = 1'b1;
   logic [ADDR_W-1:0] ptr     = 12'h000;
   logic [DATA_W-1:0] mem_rdata;
   ibs_mem_s          mem;
   logic              acc;
   logic              done;
   logic              unc;
   int                mismatches = 0;
   int                tests_run  = 0;

   always #25 ref_clk = ~ref_clk;

   ibs_exec DUT (.ref_clk(ref_clk), .nrst(nrst), .insn(insn), .extended_set_enable(ext),
      .stack_frame_pointer(ptr), .mem_rdata(mem_rdata), .mem(mem), .insn_accept(acc),
      .insn_done(done), .insn_unclaimed(unc));
   ibs_mem_model mdl (.ref_clk(ref_clk), .mem(mem), .mem_rdata(mem_rdata));

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic stop_test();
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test

   // offers one word and logs in which cycle after the take each output pulses
   task automatic run(input logic [15:0] w, input logic [11:0] p, input logic [11:0] ea,
                      input logic [7:0] ed, input logic cl, input logic rd_exp);
      int          ac, rc, wc, dc, uc;
      logic [11:0] wa;
      logic [11:0] ra;
      logic [7:0]  wd;
      ac = -1; rc = -1; wc = -1; dc = -1; uc = -1;
      @(posedge ref_clk);
      insn <= '{1'b1, w};
      ptr  <= p;
      for (int i = 0; i < 8; i++)
      begin
         @(posedge ref_clk);
         insn.valid <= 1'b0;
         #1;
         if (acc === 1'b1) ac = i;
         if (mem.rd === 1'b1)
         begin
            rc = i;
            ra = mem.addr;
         end
         if (mem.wr === 1'b1)
         begin
            wc = i;
            wa = mem.addr;
            wd = mem.wdata;
         end
         if (done === 1'b1) dc = i;
         if (unc === 1'b1) uc = i;
      end
      if (cl)
      begin
         chk(16'(ac), 16'd0);
         chk(16'(wc - ac), 16'd3);
         chk(16'(dc), 16'd3);
         chk(16'(rc), rd_exp ? 16'(ac + 1) : 16'hFFFF);
         if (rd_exp)
            chk({4'h0, ra}, {4'h0, ea});
         chk({4'h0, wa}, {4'h0, ea});
         chk({8'h00, wd}, {8'h00, ed});
         chk({8'h00, mdl.m[ea]}, {8'h00, ed});
         chk(16'(uc), 16'hFFFF);
      end
      else
      begin
         chk(16'(ac), 16'hFFFF);
         chk(16'(wc), 16'hFFFF);
         chk(16'(rc), 16'hFFFF);
         chk(16'(uc), 16'd0);
      end
   endtask : run

   task automatic t_bitset();
      for (int b = 0; b < 8; b++)
      begin
         mdl.m[12'hA0A] = 8'h55;
         run({4'h8, 3'(b), 1'b0, 8'h0A}, 12'hA00, 12'hA0A, 8'h55 | (8'h01 << b), 1'b1, 1'b1);
      end
      mdl.m[12'h04F] = 8'h80;
      run({4'h8, 3'h0, 1'b0, 8'h5F}, 12'hFF0, 12'h04F, 8'h81, 1'b1, 1'b1);
   endtask : t_bitset

   task automatic t_fill();
      mdl.m[12'hA2C] = 8'h00;
      run({8'h68, 8'h2C}, 12'hA00, 12'hA2C, FILL_VALUE, 1'b1, 1'b0);
      mdl.m[12'h05E] = 8'h3C;
      run({8'h68, 8'h5F}, 12'hFFF, 12'h05E, 8'hFF, 1'b1, 1'b0);
   endtask : t_fill

   task automatic t_refuse();
      run({4'h8, 3'h1, 1'b0, 8'h60}, 12'h100, 12'h0, 8'h0, 1'b0, 1'b0);
      run({4'h8, 3'h1, 1'b1, 8'h10}, 12'h100, 12'h0, 8'h0, 1'b0, 1'b0);
      run({8'h68, 8'h60}, 12'h100, 12'h0, 8'h0, 1'b0, 1'b0);
      run(16'h0000, 12'h100, 12'h0, 8'h0, 1'b0, 1'b0);
      @(posedge ref_clk);
      ext <= 1'b0;
      repeat (4) @(posedge ref_clk);
      run({8'h68, 8'h10}, 12'h100, 12'h0, 8'h0, 1'b0, 1'b0);
      @(posedge ref_clk);
      ext <= 1'b1;
      repeat (4) @(posedge ref_clk);
      run({8'h68, 8'h10}, 12'h100, 12'h110, 8'hFF, 1'b1, 1'b0);
   endtask : t_refuse

   initial
   begin
      repeat (6) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge ref_clk);
      t_bitset();
      t_fill();
      t_refuse();
      stop_test();
   end

   initial
   begin
      #200000;
      mismatches++;
      stop_test();
   end
endmodule : indexed_bit_set_fill_exec_tb_top
